// ==== hdl/scm_top.sv ====
// Summary of operation
// - Config register 0x07 enables positive and negative arms separately; both off at reset.
// - Negative supply node shorted to ground while negative arm disabled.
// - Voltage output mode targets fixed plus and minus 15.0 V rails.
// - Current mode targets follow range; negative rail only in bipolar 24 mA range.
// - Clamp mode 00 tracks adaptively, 4 V floor on the positive rail only, 3 V headroom.
// - Clamp mode 01 takes minimum rails from the two 4-bit clamp fields.
// - Clamp mode 10 senses load and fixes a minimum positive level.
// - Learn completion sets learn-done bit in status register 0x0B.
// - Positive clamp field is read-only while auto-learn is selected.
// - Each host write of mode 10 starts one new learning pass.
// - Positive rail maximum is 32 V, or 26 V with high-side limit set.
// - Logic regulator runs when select pin floats high, off when tied low.
// - Internal reference off after reset; register 0x02 bit turns it on.
// - Reset restores registers, disables outputs and converter, current pin high impedance.
// - Voltage pin pulled down by 30k after reset, optional high impedance, released when enabled.
`timescale 1ns/1ps
`default_nettype none
module scm_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Register port
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic [15:0]      reg_rdata,
    // Analog feedback
    input  wire logic [9:0]  load_dv,
    input  wire logic [9:0]  neg_load_dv,
    // Pins
    input  wire logic        logic_supply_regulator_select,
    // Analog controls
    output logic             pos_arm_en,
    output logic             neg_arm_en,
    output logic             negative_supply_input_gnd,
    output logic [9:0]       pos_target_dv,
    output logic [9:0]       neg_target_dv,
    output logic [9:0]       pos_max_dv,
    output logic             tracking_en,
    output logic             regulator_en,
    output logic             reference_en,
    output logic             current_output_en,
    output logic             current_output_pin_oe_n,
    output logic             voltage_output_en,
    output logic             voltage_output_pulldown
);
    import scm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] conv_r, ref_r, out_r, dac_r, limit_r;
    logic [1:0]  pin_sync_r;
    logic        learn_start_r;
    logic        learn_done_r;
    logic        learn_done_pulse;
    logic [3:0]  learned_level;

    wire wr_conv   = reg_wr && (reg_addr == CONV_CFG_ADDR);
    wire wr_ref    = reg_wr && (reg_addr == REF_CFG_ADDR);
    wire wr_out    = reg_wr && (reg_addr == OUT_CFG_ADDR);
    wire wr_dac    = reg_wr && (reg_addr == DAC_DATA_ADDR);
    wire wr_stat   = reg_wr && (reg_addr == STATUS_ADDR);
    wire wr_limit  = reg_wr && (reg_addr == LIMIT_CFG_ADDR);

    wire [1:0] supply_clamp_mode    = conv_r[CLAMP_MODE_LSB +: 2];
    wire [3:0] positive_clamp_level = conv_r[POS_CLAMP_LSB +: 4];
    wire [3:0] negative_clamp_level = conv_r[NEG_CLAMP_LSB +: 4];
    wire [1:0] new_mode             = reg_wdata[CLAMP_MODE_LSB +: 2];
    wire       learn_sel            = (supply_clamp_mode == CLAMP_LEARN);
    wire       fixed_sel            = (supply_clamp_mode == CLAMP_FIXED);
    wire       cur_mode             = out_r[CUR_MODE_BIT];
    wire [2:0] output_range_select  = out_r[RANGE_LSB +: 3];
    wire       bipolar              = (output_range_select == RANGE_BIPOLAR_24MA);
    wire       high_side_limit_select = limit_r[HS_LIMIT_BIT];
    wire       voltage_output_off_state = out_r[OFF_STATE_BIT];

    // Positive clamp field holds while learning is selected or when the write itself selects learning
    wire [15:0] conv_wmask = (new_mode == CLAMP_LEARN || learn_sel) ?
                             ~(16'hf << POS_CLAMP_LSB) : 16'hffff;
    wire [15:0] conv_nxt   = (conv_r & ~conv_wmask) | (reg_wdata & conv_wmask);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            conv_r <= CONV_CFG_RST;
            ref_r  <= REG_RST;
            out_r  <= REG_RST;
            dac_r  <= REG_RST;
            limit_r <= REG_RST;
        end else begin
            if (wr_conv) begin
                conv_r <= conv_nxt;
            end else if (learn_done_pulse && learn_sel) begin
                conv_r[POS_CLAMP_LSB +: 4] <= learned_level;
            end
            if (wr_ref) begin
                ref_r <= reg_wdata;
            end
            if (wr_out) begin
                out_r <= reg_wdata;
            end
            if (wr_dac) begin
                dac_r <= reg_wdata;
            end
            if (wr_limit) begin
                limit_r <= reg_wdata;
            end
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            learn_done_r  <= 1'b0;
            learn_start_r <= 1'b0;
            pin_sync_r    <= 2'h0;
        end else begin
            learn_start_r <= wr_conv && (new_mode == CLAMP_LEARN);
            pin_sync_r    <= {pin_sync_r[0], logic_supply_regulator_select};
            if (learn_done_pulse) begin
                learn_done_r <= 1'b1;
            end else if (wr_stat && reg_wdata[LEARN_DONE_BIT]) begin
                learn_done_r <= 1'b0;
            end
        end
    end

    scm_learn u_learn (
        .clk     (clk),
        .rstn    (rstn),
        .start   (learn_start_r),
        .active  (learn_sel),
        .load_dv (load_dv),
        .done    (learn_done_pulse),
        .level   (learned_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // Supply targets
    wire [9:0] track_pos = (load_dv + HEADROOM_DV < TRACK_FLOOR_DV) ?
                           TRACK_FLOOR_DV : load_dv + HEADROOM_DV;
    wire [9:0] track_neg = neg_load_dv + HEADROOM_DV;
    wire [9:0] clamp_pos = 10'(positive_clamp_level) * CLAMP_STEP_DV;
    wire [9:0] clamp_neg = 10'(negative_clamp_level) * CLAMP_STEP_DV;
    wire [9:0] floor_pos = (fixed_sel || learn_sel) ? clamp_pos : TRACK_FLOOR_DV;
    wire [9:0] floor_neg = fixed_sel ? clamp_neg : 10'd0;
    wire [9:0] cur_pos   = (track_pos < floor_pos) ? floor_pos : track_pos;
    wire [9:0] cur_neg   = (track_neg < floor_neg) ? floor_neg : track_neg;
    wire [9:0] max_pos   = high_side_limit_select ? POS_MAX_LIM_DV : POS_MAX_DV;
    wire [9:0] raw_pos   = cur_mode ? cur_pos : VOLTAGE_OUTPUT_PIN_RAIL_DV;
    wire [9:0] raw_neg   = cur_mode ? (bipolar ? cur_neg : 10'd0) : VOLTAGE_OUTPUT_PIN_RAIL_DV;

    assign pos_arm_en                = conv_r[POS_ARM_BIT];
    assign neg_arm_en                = conv_r[NEG_ARM_BIT] && (!cur_mode || bipolar);
    assign negative_supply_input_gnd = !neg_arm_en;
    assign pos_max_dv                = max_pos;
    assign pos_target_dv             = (raw_pos > max_pos) ? max_pos : raw_pos;
    assign neg_target_dv             = neg_arm_en ? raw_neg : 10'd0;
    assign tracking_en               = cur_mode && !fixed_sel && !learn_sel;
    assign regulator_en              = pin_sync_r[1];
    assign reference_en              = ref_r[REF_EN_BIT];
    assign current_output_en         = out_r[CURRENT_OUTPUT_PIN_EN_BIT];
    assign current_output_pin_oe_n   = !out_r[CURRENT_OUTPUT_PIN_EN_BIT];
    assign voltage_output_en         = out_r[VOLTAGE_OUTPUT_PIN_EN_BIT];
    assign voltage_output_pulldown   = !out_r[VOLTAGE_OUTPUT_PIN_EN_BIT] && !voltage_output_off_state;

    ////////////////////////////////////////////////////////////////////////
    wire [15:0] status_word = 16'(learn_done_r) << LEARN_DONE_BIT;
    wire [15:0] rd_mux = (reg_addr == CONV_CFG_ADDR)  ? conv_r  :
                         (reg_addr == REF_CFG_ADDR)   ? ref_r   :
                         (reg_addr == OUT_CFG_ADDR)   ? out_r   :
                         (reg_addr == DAC_DATA_ADDR)  ? dac_r   :
                         (reg_addr == STATUS_ADDR)    ? status_word :
                         (reg_addr == LIMIT_CFG_ADDR) ? limit_r : 16'h0000;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end
endmodule
`default_nettype wire

// ==== hdl/scm_pkg.sv ====
package scm_pkg;
    // Register offsets
    localparam logic [7:0]  REF_CFG_ADDR       = 8'h02;
    localparam logic [7:0]  OUT_CFG_ADDR       = 8'h04;
    localparam logic [7:0]  CONV_CFG_ADDR      = 8'h07;
    localparam logic [7:0]  DAC_DATA_ADDR      = 8'h05;
    localparam logic [7:0]  STATUS_ADDR        = 8'h0b;
    localparam logic [7:0]  LIMIT_CFG_ADDR     = 8'h0e;
    // Reset values
    localparam logic [15:0] CONV_CFG_RST       = 16'h0000;
    localparam logic [15:0] REG_RST            = 16'h0000;
    // converter_config fields
    localparam int          POS_ARM_BIT        = 0;
    localparam int          NEG_ARM_BIT        = 1;
    localparam int          CLAMP_MODE_LSB     = 2;
    localparam int          POS_CLAMP_LSB      = 4;
    localparam int          NEG_CLAMP_LSB      = 8;
    // Other fields
    localparam int          REF_EN_BIT         = 0;
    localparam int          VOLTAGE_OUTPUT_PIN_EN_BIT        = 0;
    localparam int          CURRENT_OUTPUT_PIN_EN_BIT        = 1;
    localparam int          CUR_MODE_BIT       = 2;
    localparam int          RANGE_LSB          = 4;
    localparam int          OFF_STATE_BIT      = 8;
    localparam int          HS_LIMIT_BIT       = 0;
    localparam int          LEARN_DONE_BIT     = 0;
    // Encodings
    localparam logic [1:0]  CLAMP_TRACK        = 2'h0;
    localparam logic [1:0]  CLAMP_FIXED        = 2'h1;
    localparam logic [1:0]  CLAMP_LEARN        = 2'h2;
    localparam logic [2:0]  RANGE_BIPOLAR_24MA = 3'h4;
    localparam logic [15:0] LEARN_MIN_CODE     = 16'h4000;
    // Supply targets in tenths of a volt
    localparam logic [9:0]  VOLTAGE_OUTPUT_PIN_RAIL_DV       = 10'd150;
    localparam logic [9:0]  TRACK_FLOOR_DV     = 10'd40;
    localparam logic [9:0]  HEADROOM_DV        = 10'd30;
    localparam logic [9:0]  POS_MAX_DV         = 10'd320;
    localparam logic [9:0]  POS_MAX_LIM_DV     = 10'd260;
    localparam logic [9:0]  CLAMP_STEP_DV      = 10'd20;
    // Learning settle time
    localparam int          LEARN_TIME_US      = 10;
    localparam int          CLK_MHZ            = 200;
    localparam int          LEARN_CYCLES       = LEARN_TIME_US * CLK_MHZ;
endpackage

// ==== hdl/scm_learn.sv ====
`timescale 1ns/1ps
`default_nettype none
module scm_learn (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Control
    input  wire logic       start,
    input  wire logic       active,
    input  wire logic [9:0] load_dv,
    // Result
    output logic            done,
    output logic [3:0]      level
);
    import scm_pkg::*;

    logic [11:0] cnt_r;
    logic        busy_r;
    logic [3:0]  level_r;
    logic        done_r;
    wire  [9:0]  want_dv = load_dv + HEADROOM_DV;
    wire  [3:0]  calc    = (want_dv >= 10'd300) ? 4'hf : 4'((want_dv / CLAMP_STEP_DV) + 10'd1);

    // Load is sampled after a settle wait so settling then depends on the core only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r   <= '0;
            busy_r  <= 1'b0;
            level_r <= 4'h0;
            done_r  <= 1'b0;
        end else begin
            // One-cycle pulse, else a status clear would lose to a standing set
            done_r <= 1'b0;
            if (start) begin
                cnt_r  <= '0;
                busy_r <= 1'b1;
            end else if (!active) begin
                busy_r <= 1'b0;
            end else if (busy_r) begin
                if (cnt_r == 12'(LEARN_CYCLES - 1)) begin
                    busy_r  <= 1'b0;
                    level_r <= calc;
                    done_r  <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 12'd1;
                end
            end
        end
    end

    assign done  = done_r;
    assign level = level_r;
endmodule
`default_nettype wire

// ==== verif/scm_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module scm_checker (
    // Clock, reset and register writes
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    // Pin and controls
    input wire logic        logic_supply_regulator_select,
    input wire logic        pos_arm_en,
    input wire logic        neg_arm_en,
    input wire logic        negative_supply_input_gnd,
    input wire logic [9:0]  pos_target_dv,
    input wire logic [9:0]  pos_max_dv,
    input wire logic        regulator_en,
    input wire logic        reference_en,
    input wire logic        current_output_en,
    input wire logic        current_output_pin_oe_n,
    input wire logic        voltage_output_en,
    input wire logic        voltage_output_pulldown
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Shadow of output mode and range, since the negative arm also follows the range
    logic cur_mode_r;
    logic bipolar_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur_mode_r <= 1'b0;
            bipolar_r  <= 1'b0;
        end else if (reg_wr && reg_addr == 8'h04) begin
            cur_mode_r <= reg_wdata[2];
            bipolar_r  <= (reg_wdata[6:4] == 3'h4);
        end
    end
    neg_gnd_a: assert property (negative_supply_input_gnd == !neg_arm_en)
        else $error("negative node grounding wrong");
    arm_wr_a: assert property (reg_wr && reg_addr == 8'h07 |=>
        pos_arm_en == $past(reg_wdata[0]) && neg_arm_en == ($past(reg_wdata[1]) && (!cur_mode_r || bipolar_r)))
        else $error("arm enable wrong");
    ref_wr_a: assert property (reg_wr && reg_addr == 8'h02 |=> reference_en == $past(reg_wdata[0]))
        else $error("reference enable wrong");
    max_sel_a: assert property (reg_wr && reg_addr == 8'h0e |=>
        pos_max_dv == ($past(reg_wdata[0]) ? 10'd260 : 10'd320)) else $error("high side limit wrong");
    max_bound_a: assert property (pos_target_dv <= pos_max_dv) else $error("target above limit");
    oe_link_a: assert property (current_output_pin_oe_n == !current_output_en)
        else $error("current pin drive wrong");
    pulldown_a: assert property (voltage_output_en |-> !voltage_output_pulldown)
        else $error("pulldown left on");
    // Two-flop sync, so the pin shows two edges late
    reg_sync_a: assert property ($past(rstn, 2) |-> regulator_en == $past(logic_supply_regulator_select, 2))
        else $error("regulator enable wrong");
    cover property (reg_wr && reg_addr == 8'h07 && reg_wdata[3:2] == 2'h2);
    cover property ($fell(regulator_en));
    cover property (voltage_output_en && !current_output_en);
endmodule
bind scm_top scm_checker chk_u (.clk, .rstn, .reg_wr, .reg_addr, .reg_wdata, .logic_supply_regulator_select,
    .pos_arm_en, .neg_arm_en, .negative_supply_input_gnd, .pos_target_dv, .pos_max_dv, .regulator_en,
    .reference_en, .current_output_en, .current_output_pin_oe_n, .voltage_output_en, .voltage_output_pulldown);
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk, rstn, reg_wr, reg_rd, sel, pa, na, ng, trk, rg, rf, ie, ioe_n, ve, vpd;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, v, lvl;
    logic [9:0]  load_dv, pos_t, neg_t, pmax;
    int          n_mismatch = 0;
    int          checks = 0;
    scm_top dut_u (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .load_dv(load_dv), .neg_load_dv(10'h020),
        .logic_supply_regulator_select(sel), .pos_arm_en(pa), .neg_arm_en(na), .negative_supply_input_gnd(ng),
        .pos_target_dv(pos_t), .neg_target_dv(neg_t), .pos_max_dv(pmax), .tracking_en(trk), .regulator_en(rg),
        .reference_en(rf), .current_output_en(ie), .current_output_pin_oe_n(ioe_n), .voltage_output_en(ve),
        .voltage_output_pulldown(vpd));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic setl(input logic [9:0] l);
        @(posedge clk);
        load_dv <= l;
        #1;
    endtask
    // Learning takes thousands of cycles, so poll with a bound
    task automatic wait_done;
        for (int i = 0; i < 3000; i++) begin
            rd(8'h0b);
            if (v[0] === 1'b1) break;
        end
        chk(v[0], 1'b1);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk({pa, na, ng, rf, ie, ioe_n, ve, vpd}, 8'b0010_0101);
        chk(pmax, 10'd320);
        rd(8'h07);
        chk(v, 16'h0000);
        rd(8'h09);
        chk(v, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            wr(8'h07, 16'(i));
            chk({pa, na, ng}, {i[0], i[1], !i[1]});
        end
        wr(8'h02, 16'h0001);
        chk(rf, 1'b1);
        $display("test reset and arms done");
    endtask
    task automatic t_voltage_output_pin;
        wr(8'h04, 16'h0001);
        chk({ve, vpd, pos_t, neg_t}, {2'b10, 10'd150, 10'd150});
        wr(8'h04, 16'h0100);
        chk(vpd, 1'b0);
        $display("test voltage mode done");
    endtask
    task automatic t_clamp;
        wr(8'h04, 16'h0006);
        chk({ioe_n, neg_t}, 11'h000);
        wr(8'h04, 16'h0046);
        chk(neg_t !== 10'd0, 1'b1);
        setl(10'd100);
        for (int m = 0; m < 4; m += 3) begin
            wr(8'h07, 16'h0003 | 16'(m << 2));
            chk({trk, pos_t}, {1'b1, 10'd130});
        end
        setl(10'd0);
        chk(pos_t, 10'd40);
        setl(10'd300);
        chk(pos_t, 10'd320);
        wr(8'h0e, 16'h0001);
        chk({pmax, pos_t}, {10'd260, 10'd260});
        wr(8'h0e, 16'h0000);
        setl(10'd0);
        wr(8'h07, 16'h0357);
        chk({trk, pos_t}, {1'b0, 10'd100});
        rd(8'h07);
        chk(v, 16'h0357);
        $display("test clamp modes done");
    endtask
    task automatic t_learn;
        wr(8'h05, 16'h8000);
        wr(8'h07, 16'h0003);
        setl(10'd60);
        wr(8'h07, 16'h000b);
        wait_done();
        rd(8'h07);
        lvl = v;
        chk(lvl[7:4] != 4'h0, 1'b1);
        wr(8'h0b, 16'h0001);
        rd(8'h0b);
        chk(v[0], 1'b0);
        wr(8'h07, 16'h00fb);
        rd(8'h07);
        chk(v[7:4], lvl[7:4]);
        wait_done();
        $display("test auto learn done");
    endtask
    task automatic t_pin;
        @(posedge clk);
        sel <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(rg, 1'b0);
        @(posedge clk);
        sel <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(rg, 1'b1);
        $display("test regulator pin done");
    endtask
    initial begin
        {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, load_dv, sel} = {27'h0, 10'h0, 1'b1};
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        t_reset();
        t_voltage_output_pin();
        t_clamp();
        t_learn();
        t_pin();
        report_and_stop();
    end
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
`default_nettype wire
